//--- hdl/sac_readout.sv
// serial command and readout sequencer of a 12-bit sampling converter
// assumes serial clock, select and data pins are synchronous to core_clk and
// each serial clock phase lasts at least two core clock cycles
`timescale 1ns/1ps
module sac_readout
    import sac_pkg::*;
#(
    parameter int NUM_CHANNELS = 8,
    parameter int LEVEL_W = 16,
    parameter int HOLD_LIMIT = HOLD_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // serial pins
    input wire logic select_shutdown_n,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    // analog front end
    input wire logic [7:0][LEVEL_W-1:0] channel_level,
    input wire logic [LEVEL_W-1:0] ref_level,
    output sac_route_type chan_route,
    output logic sample_en,
    output logic analog_power,
    output logic ref_connect,
    output logic standby,
    // status
    output logic input_mode_bit,
    output logic hold_late
);

    sac_state_type state;
    logic sclk_d;
    logic sclk_q;
    logic cs_n_d;
    logic din_d;
    logic rise;
    logic fall;
    logic [5:0] idx;
    logic [5:0] next_idx;
    logic chan_sel_hi;
    logic chan_sel_mid;
    logic chan_sel_lo;
    logic calc_start;
    logic calc_valid;
    logic calc_ready;
    logic [RES_BITS-1:0] calc_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [RES_BITS-1:0] fifo_data;
    logic [RES_BITS-1:0] result;
    logic loaded;
    logic holding;
    logic [31:0] hold_count;

    // four-channel part drops the top select bit
    function automatic logic [2:0] eff_sel(input logic [2:0] sel);
        eff_sel = (NUM_CHANNELS == 4) ? {1'b0, sel[1:0]} : sel;
    endfunction

    function automatic sac_route_type decode_route(
        input logic mode,
        input logic [2:0] sel
    );
        logic [2:0] s;
        s = eff_sel(sel);
        decode_route.pos = s;
        decode_route.neg = 3'h0;
        decode_route.neg_gnd = 1'b1;
        // even or odd member is positive
        if (mode == MODE_PSEUDO_DIFF) begin
            decode_route.pos = {s[2:1], s[0]};
            decode_route.neg = {s[2:1], ~s[0]};
            decode_route.neg_gnd = 1'b0;
        end
    endfunction

    // picks the serial bit for a falling edge at the given slot
    function automatic logic pick_bit(
        input logic [5:0] slot,
        input logic [RES_BITS-1:0] word
    );
        logic [5:0] pos;
        pos = 6'h00;
        pick_bit = 1'b0;
        if (slot >= IDX_MSB_FIRST && slot < IDX_LSB_FIRST) begin
            pos = IDX_LSB_FIRST - 6'h01 - slot;
            pick_bit = word[pos[3:0]];
        end else if (slot >= IDX_LSB_FIRST && slot < IDX_ZEROS) begin
            pos = slot - (IDX_LSB_FIRST - 6'h01);
            pick_bit = word[pos[3:0]];
        end
    endfunction

    assign rise = sclk_d && !sclk_q;
    assign fall = !sclk_d && sclk_q;
    assign next_idx = (idx == IDX_LAST) ? idx : idx + 6'h01;

    // pin sampling
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_d <= 1'b0;
            sclk_q <= 1'b0;
            cs_n_d <= 1'b1;
            din_d <= 1'b0;
        end else begin
            sclk_d <= sclk;
            sclk_q <= sclk_d;
            cs_n_d <= select_shutdown_n;
            din_d <= din;
        end
    end

    // sequencer state
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SEQ_WAIT_ARM;
        end else if (cs_n_d) begin
            // armed only after select seen high, not the reset value of cs_n_d
            if (state != SEQ_WAIT_ARM || select_shutdown_n) begin
                state <= SEQ_HUNT;
            end
        end else begin
            unique case (state)
                SEQ_WAIT_ARM: begin
                    state <= SEQ_WAIT_ARM;
                end
                SEQ_HUNT: begin
                    if (rise && din_d) begin
                        state <= SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    state <= SEQ_RUN;
                end
            endcase
        end
    end

    // rising-edge slot counter
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idx <= IDX_START;
        end else if (cs_n_d || state != SEQ_RUN) begin
            idx <= IDX_START;
        end else if (rise) begin
            idx <= next_idx;
        end
    end

    // command latch
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            input_mode_bit <= MODE_SINGLE;
            chan_sel_hi <= 1'b0;
            chan_sel_mid <= 1'b0;
            chan_sel_lo <= 1'b0;
        end else if (state == SEQ_RUN && !cs_n_d && rise) begin
            if (next_idx == IDX_MODE) begin
                input_mode_bit <= din_d;
            end
            if (next_idx == IDX_SEL_HI) begin
                chan_sel_hi <= din_d;
            end
            if (next_idx == IDX_SEL_MID) begin
                chan_sel_mid <= din_d;
            end
            if (next_idx == IDX_SEL_LO) begin
                chan_sel_lo <= din_d;
            end
            // sample clock input is not stored
        end
    end

    // multiplexer routing, set as sampling starts
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chan_route <= '0;
        end else if (state == SEQ_RUN && !cs_n_d && rise && next_idx == IDX_SEL_LO) begin
            chan_route <= decode_route(input_mode_bit, {chan_sel_hi, chan_sel_mid, din_d});
        end
    end

    // acquisition window
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_en <= 1'b0;
        end else if (cs_n_d || state != SEQ_RUN) begin
            sample_en <= 1'b0;
        end else if (rise && next_idx == IDX_SEL_LO) begin
            sample_en <= 1'b1;
        end else if (fall && idx == IDX_SAMPLE) begin
            sample_en <= 1'b0;
        end
    end

    // conversion request at the end of sampling
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            calc_start <= 1'b0;
        end else begin
            calc_start <= !cs_n_d && state == SEQ_RUN && fall && idx == IDX_SAMPLE;
        end
    end

    sac_code_calc #(
        .LEVEL_W(LEVEL_W)
    ) u_calc (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(calc_start),
        .pos_level(channel_level[chan_route.pos]),
        .neg_level(chan_route.neg_gnd ? '0 : channel_level[chan_route.neg]),
        .ref_level(ref_level),
        .out_valid(calc_valid),
        .out_ready(calc_ready),
        .out_data(calc_data)
    );

    sac_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(calc_valid),
        .in_ready(calc_ready),
        .in_data(calc_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // load once per transfer; words left from aborted transfers are drained while idle
    assign fifo_pop = fifo_valid && (state != SEQ_RUN || (!loaded && idx >= IDX_SAMPLE));

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= CODE_ZERO;
            loaded <= 1'b0;
        end else if (state != SEQ_RUN || cs_n_d) begin
            loaded <= 1'b0;
        end else if (fifo_pop) begin
            result <= fifo_data;
            loaded <= 1'b1;
        end
    end

    // serial output
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dout <= DOUT_RESET;
            dout_oe <= 1'b0;
        end else if (cs_n_d || state != SEQ_RUN) begin
            dout <= DOUT_RESET;
            dout_oe <= 1'b0;
        end else if (fall) begin
            if (idx == IDX_SAMPLE) begin
                dout <= 1'b0;
                dout_oe <= 1'b1;
            end else if (idx > IDX_SAMPLE) begin
                dout <= loaded ? pick_bit(idx, result) : 1'b0;
            end
        end
    end

    // comparator, bias and reference power
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            analog_power <= 1'b0;
            ref_connect <= 1'b0;
        end else if (cs_n_d || state != SEQ_RUN) begin
            analog_power <= 1'b0;
            ref_connect <= 1'b0;
        end else if (rise && idx == IDX_START) begin
            analog_power <= 1'b1;
            ref_connect <= 1'b1;
        end else if (fall && idx == IDX_LSB_FIRST) begin
            // power down for LSB-first and zeros
            analog_power <= 1'b0;
            ref_connect <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            standby <= 1'b1;
        end else begin
            standby <= cs_n_d;
        end
    end

    // charge holding watchdog from sampling end to the last MSB-first bit
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            holding <= 1'b0;
            hold_count <= '0;
            hold_late <= 1'b0;
        end else if (state == SEQ_HUNT && rise && din_d && !cs_n_d) begin
            holding <= 1'b0;
            hold_count <= '0;
            hold_late <= 1'b0;
        end else if (cs_n_d || state != SEQ_RUN) begin
            holding <= 1'b0;
        end else if (fall && idx == IDX_SAMPLE) begin
            holding <= 1'b1;
            hold_count <= '0;
        end else if (holding) begin
            if (idx >= IDX_LSB_FIRST) begin
                holding <= 1'b0;
            end else if (hold_count >= 32'(HOLD_LIMIT)) begin
                hold_late <= 1'b1;
            end else begin
                hold_count <= hold_count + 32'h00000001;
            end
        end
    end

endmodule

//--- hdl/sac_pkg.sv
// shared constants and types of the serial command and readout sequencer
// assumes one 25 MHz core clock; all serial pins are sampled on it
package sac_pkg;

    // core clock and the charge holding limit after sampling ends
    localparam int CLK_MHZ = 25;
    localparam int HOLD_TIME_US = 1200;
    localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;

    // result format
    localparam int RES_BITS = 12;
    localparam int CODE_SCALE_SHIFT = 12;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_FULL = 12'hFFF;

    // rising-edge index after the start bit of each serial slot
    localparam logic [5:0] IDX_START = 6'h00;
    localparam logic [5:0] IDX_MODE = 6'h01;
    localparam logic [5:0] IDX_SEL_HI = 6'h02;
    localparam logic [5:0] IDX_SEL_MID = 6'h03;
    localparam logic [5:0] IDX_SEL_LO = 6'h04;
    localparam logic [5:0] IDX_SAMPLE = 6'h05;
    localparam logic [5:0] IDX_MSB_FIRST = 6'h06;
    localparam logic [5:0] IDX_LSB_FIRST = 6'h12;
    localparam logic [5:0] IDX_ZEROS = 6'h1D;
    localparam logic [5:0] IDX_LAST = 6'h3F;

    // input mode bit values
    localparam logic MODE_SINGLE = 1'b1;
    localparam logic MODE_PSEUDO_DIFF = 1'b0;

    // reset values
    localparam logic DOUT_RESET = 1'b0;
    localparam logic [15:0] HOLD_COUNT_RESET = 16'h0000;

    // buffering
    localparam int FIFO_DEPTH = 32;

    // multiplexer routing handed to the analog front end
    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic neg_gnd;
    } sac_route_type;

    typedef enum logic [1:0] {
        SEQ_WAIT_ARM,
        SEQ_HUNT,
        SEQ_RUN
    } sac_state_type;

endpackage

//--- hdl/sac_fifo.sv
// first-in first-out buffer of result words between code calculation and readout
// assumes both sides run on core_clk; a word moves when valid and ready are both high
`timescale 1ns/1ps
module sac_fifo
    import sac_pkg::*;
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign out_valid = wr_ptr != rd_ptr;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + (AW+1)'(1);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + (AW+1)'(1);
        end
    end

endmodule

//--- hdl/sac_code_calc.sv
// turns held input levels into the unsigned result code
// assumes levels are digitised front-end readings in one common unit
`timescale 1ns/1ps
module sac_code_calc
    import sac_pkg::*;
#(
    parameter int LEVEL_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // held levels and request
    input wire logic start,
    input wire logic [LEVEL_W-1:0] pos_level,
    input wire logic [LEVEL_W-1:0] neg_level,
    input wire logic [LEVEL_W-1:0] ref_level,
    // result toward the buffer
    output logic out_valid,
    input wire logic out_ready,
    output logic [RES_BITS-1:0] out_data
);

    function automatic logic [RES_BITS-1:0] ideal_code(
        input logic [LEVEL_W-1:0] pos,
        input logic [LEVEL_W-1:0] neg,
        input logic [LEVEL_W-1:0] vref
    );
        logic [LEVEL_W-1:0] diff;
        logic [LEVEL_W+CODE_SCALE_SHIFT-1:0] scaled;
        diff = '0;
        scaled = '0;
        if (pos > neg) begin
            diff = pos - neg;
        end
        if (vref == '0) begin
            scaled = '1;
        end else begin
            scaled = {diff, {CODE_SCALE_SHIFT{1'b0}}} / {{CODE_SCALE_SHIFT{1'b0}}, vref};
        end
        if (scaled > {{(LEVEL_W+CODE_SCALE_SHIFT-RES_BITS){1'b0}}, CODE_FULL}) begin
            ideal_code = CODE_FULL;
        end else begin
            ideal_code = scaled[RES_BITS-1:0];
        end
    endfunction

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
            out_data <= CODE_ZERO;
        end else if (start && (!out_valid || out_ready)) begin
            out_valid <= 1'b1;
            out_data <= ideal_code(pos_level, neg_level, ref_level);
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule

//--- testbench/sac_readout_assertions.sv
// pin-level checker of the serial command and readout sequencer
// assumes serial clock phases of at least four core cycles
`timescale 1ns/1ps
module sac_readout_assertions
    import sac_pkg::*;
#(
    parameter int NUM_CHANNELS = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // serial pins
    input wire logic select_shutdown_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic dout_oe,
    // front end and status
    input wire sac_route_type chan_route,
    input wire logic sample_en,
    input wire logic analog_power,
    input wire logic ref_connect,
    input wire logic standby,
    input wire logic input_mode_bit
);
    logic sclk_prev;
    logic [3:0] fall_age;
    logic [3:0] rise_age;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // core cycles since the last serial clock edge of each kind, saturating
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_prev <= 1'b0;
            fall_age <= 4'hF;
            rise_age <= 4'hF;
        end else begin
            sclk_prev <= sclk;
            fall_age <= (sclk_prev && !sclk) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hF};
            rise_age <= (!sclk_prev && sclk) ? 4'h0 : rise_age + {3'h0, rise_age != 4'hF};
        end
    end

    sequence s_deselected;
        select_shutdown_n [*4];
    endsequence
    sequence s_fresh_bit;
        dout_oe && $past(dout_oe) && $changed(dout);
    endsequence

    a_out_on_fall: assert property (
        s_fresh_bit |-> fall_age <= 4'h5)
        else $error("dout moved away from a falling serial edge");
    a_null_first: assert property (
        $rose(dout_oe) |-> !dout && fall_age <= 4'h5)
        else $error("first driven bit is not a low bit on a falling edge");
    a_hiz_at_start: assert property (
        $fell(select_shutdown_n) |-> !dout_oe [*8])
        else $error("dout driven right after select went low");
    a_idle_standby: assert property (
        s_deselected |-> standby && !dout_oe)
        else $error("no standby while deselected");
    a_idle_quiet: assert property (
        s_deselected |-> !sample_en && !analog_power)
        else $error("activity while deselected");
    a_sample_open: assert property (
        $rose(sample_en) |-> rise_age <= 4'h5)
        else $error("sampling did not open on a rising serial edge");
    a_sample_close: assert property (
        $fell(sample_en) && !select_shutdown_n |-> fall_age <= 4'h5 && dout_oe && !dout)
        else $error("sampling did not close with the null bit");
    a_ref_with_power: assert property (
        ref_connect == analog_power)
        else $error("reference connection differs from comparator power");
    a_power_drop: assert property (
        $fell(analog_power) && !select_shutdown_n |-> dout_oe && fall_age <= 4'h5)
        else $error("comparator powered down outside the readout");
    a_route_single: assert property (
        sample_en && $past(sample_en) && input_mode_bit |-> chan_route.neg_gnd)
        else $error("single-ended route not against ground");
    a_route_pair: assert property (
        sample_en && $past(sample_en) && !input_mode_bit |-> !chan_route.neg_gnd
            && chan_route.neg == {chan_route.pos[2:1], !chan_route.pos[0]})
        else $error("pseudo-differential route is not an adjacent pair");
    a_four_chan: assert property (
        sample_en && $past(sample_en) && NUM_CHANNELS == 4 |-> !chan_route.pos[2])
        else $error("four-channel route uses an upper channel");
endmodule

bind sac_readout sac_readout_assertions #(.NUM_CHANNELS(NUM_CHANNELS)) i_chk (
    .core_clk(core_clk), .reset_n(reset_n), .select_shutdown_n(select_shutdown_n),
    .sclk(sclk), .dout(dout), .dout_oe(dout_oe), .chan_route(chan_route),
    .sample_en(sample_en), .analog_power(analog_power), .ref_connect(ref_connect),
    .standby(standby), .input_mode_bit(input_mode_bit));

//--- testbench/sac_spi_master.sv
// serial master model driving select, clock and data of two sequencers
// assumes pins change on core_clk falling edges; serial clock idles low
`timescale 1ns/1ps
module sac_spi_master (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic select_shutdown_n,
    output logic sclk,
    output logic din,
    input wire logic [1:0] miso,
    input wire logic [1:0] miso_oe
);
    // core cycles per serial clock phase
    int half = 4;

    initial begin
        select_shutdown_n = 1'b0;
        sclk = 1'b0;
        din = 1'b0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // flags[0]: device 0 drove before the null slot, flags[1]: it drove while read
    task automatic xfer(input int pad, input logic [3:0] cmd, input int nrx,
                        output logic [1:0][27:0] rx, output logic [1:0] flags);
        rx = '0;
        flags = 2'b00;
        @(negedge core_clk);
        select_shutdown_n = 1'b0;
        wait_cyc(half);
        for (int k = 0; k < pad + 6 + nrx; k++) begin
            if (k < pad) din = 1'b0;
            else if (k == pad) din = 1'b1;
            else if (k <= pad + 4) din = cmd[pad + 4 - k];
            else din = ~din;
            // phases short enough for the hold limit unless slowed
            wait_cyc(half);
            sclk = 1'b1;
            if (k >= pad + 6) begin
                rx[0] = {rx[0][26:0], miso[0]};
                rx[1] = {rx[1][26:0], miso[1]};
                flags[1] = flags[1] | miso_oe[0];
            end else begin
                flags[0] = flags[0] | miso_oe[0];
            end
            wait_cyc(half);
            sclk = 1'b0;
        end
        wait_cyc(half);
        select_shutdown_n = 1'b1;
        din = ~din;
        wait_cyc(8);
    endtask
endmodule

//--- testbench/tb.sv
// self-checking bench: eight- and four-channel sequencers on one serial master
// assumes reference level 1000h, so a code equals the input level difference
`timescale 1ns/1ps
module tb;
    import sac_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic select_shutdown_n;
    logic sclk;
    logic din;
    logic [1:0] miso;
    logic [1:0] miso_oe;
    logic [1:0] standby;
    logic [1:0] mode_bit;
    logic [1:0] late;
    logic [7:0][15:0] lvl = {16'h1200, 16'h0020, 16'h0010, 16'h0F00,
                             16'h0ABC, 16'h0ABC, 16'h0345, 16'h0100};
    logic [1:0][27:0] rx;
    logic [1:0] flags;
    int error_cnt = 0;
    int checks_done = 0;

    always #20 core_clk = ~core_clk;

    for (genvar g = 0; g < 2; g++) begin : g_dut
        sac_readout #(.NUM_CHANNELS(8 >> g), .HOLD_LIMIT(200)) i_dut (
            .core_clk(core_clk), .reset_n(reset_n), .select_shutdown_n(select_shutdown_n),
            .sclk(sclk), .din(din), .dout(miso[g]), .dout_oe(miso_oe[g]),
            .channel_level(lvl), .ref_level(16'h1000), .chan_route(), .sample_en(),
            .analog_power(), .ref_connect(), .standby(standby[g]),
            .input_mode_bit(mode_bit[g]), .hold_late(late[g]));
    end

    sac_spi_master i_mst (.core_clk(core_clk), .select_shutdown_n(select_shutdown_n),
        .sclk(sclk), .din(din), .miso(miso), .miso_oe(miso_oe));

    task automatic check(input logic [27:0] seen, input logic [27:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // null bit, MSB-first code, B1..B11, then four zeros
    function automatic logic [27:0] exp_rx(input logic [3:0] cmd, input int g);
        logic [2:0] p;
        logic [2:0] n;
        logic [16:0] d;
        logic [27:0] s;
        p = (g == 1) ? {1'b0, cmd[1:0]} : cmd[2:0];
        n = {p[2:1], ~p[0]};
        d = 17'h0;
        if (cmd[3]) d = {1'b0, lvl[p]};
        else if (lvl[p] > lvl[n]) d = {1'b0, lvl[p]} - {1'b0, lvl[n]};
        if (d > 17'h00FFF) d = 17'h00FFF;
        s = {1'b0, d[11:0], 15'h0};
        for (int i = 1; i < 12; i++) s[15 - i] = d[i];
        return s;
    endfunction

    task automatic run(input int pad, input logic [3:0] cmd);
        i_mst.xfer(pad, cmd, 28, rx, flags);
        check({26'h0, flags}, 28'h2);
        check(rx[0], exp_rx(cmd, 0));
        check(rx[1], exp_rx(cmd, 1));
        check({26'h0, mode_bit}, {26'h0, cmd[3], cmd[3]});
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        i_mst.xfer(0, 4'h8, 28, rx, flags);
        check({26'h0, flags}, 28'h0);
        $display("test power_up_low done");
        for (int c = 0; c < 8; c++) run(c % 6, {1'b1, c[2:0]});
        $display("test single_ended done");
        for (int c = 0; c < 8; c++) run(5, {1'b0, c[2:0]});
        $display("test pseudo_differential done");
        i_mst.xfer(2, 4'hB, 5, rx, flags);
        check({26'h0, standby}, 28'h3);
        run(0, 4'hB);
        $display("test abort done");
        check({26'h0, late}, 28'h0);
        i_mst.half = 10;
        run(0, 4'hF);
        check({26'h0, late}, 28'h3);
        $display("test slow_clock done");
        end_of_test();
    end

    // about twenty transfers of at most 800 cycles each
    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        end_of_test();
    end
endmodule
